//--- iex_defines.svh
// Purpose: offsets, field positions, reset values of the execution block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   included by the main module only
`ifndef IEX_DEFINES_SVH
`define IEX_DEFINES_SVH

`define IEX_ADDR_W       8
// register byte offsets
`define IEX_OFS_OPA      8'h00
`define IEX_OFS_OPB      8'h04
`define IEX_OFS_IMM      8'h08
`define IEX_OFS_ACC_LO   8'h0c
`define IEX_OFS_ACC_HI   8'h10
`define IEX_OFS_CMD      8'h14
`define IEX_OFS_RES_LO   8'h18
`define IEX_OFS_RES_HI   8'h1c
`define IEX_OFS_FLAGS    8'h20
`define IEX_OFS_STATUS   8'h24
`define IEX_OFS_TARGET   8'h28
// command word fields
`define IEX_CMD_OP_MSB   5
`define IEX_CMD_OP_LSB   0
`define IEX_CMD_COND_MSB 11
`define IEX_CMD_COND_LSB 8
`define IEX_CMD_USE_IMM  12
`define IEX_CMD_SETF     13
`define IEX_CMD_WBACK    14
`define IEX_CMD_CNT_MSB  20
`define IEX_CMD_CNT_LSB  16
// flag word fields
`define IEX_FLG_N        31
`define IEX_FLG_Z        30
`define IEX_FLG_C        29
`define IEX_FLG_V        28
`define IEX_FLG_Q        27
// status word fields
`define IEX_ST_DONE      0
`define IEX_ST_TAKEN     1
`define IEX_ST_IRQ_OFF   2
`define IEX_ST_SKIPPED   3
// reset values and the always condition code
`define IEX_RST_WORD     32'h0000_0000
`define IEX_RST_FLAGS    5'h00
`define IEX_COND_AL      4'he
`endif

//--- iex_pkg.sv
// Purpose: types shared by the execution block files
// Assumes: iex_defines.svh for numeric constants
// Notes:   opcode codes are the low six bits of the command word
package iex_pkg;

   typedef enum logic [5:0] {
      IEX_NOP                        = 6'h00,
      IEX_ADD                        = 6'h01,
      IEX_ADC                        = 6'h02,
      IEX_SUB                        = 6'h03,
      IEX_SBC                        = 6'h04,
      IEX_RSB                        = 6'h05,
      IEX_CMP                        = 6'h06,
      IEX_CMN                        = 6'h07,
      IEX_AND                        = 6'h08,
      IEX_ORR                        = 6'h09,
      IEX_EOR                        = 6'h0a,
      IEX_BIC                        = 6'h0b,
      IEX_MOV                        = 6'h0c,
      IEX_MVN                        = 6'h0d,
      IEX_LSL                        = 6'h0e,
      IEX_LSR                        = 6'h0f,
      IEX_ASR                        = 6'h10,
      IEX_ROR                        = 6'h11,
      IEX_MUL_ACCUMULATE_OP          = 6'h12,
      IEX_MUL_SUBTRACT_OP            = 6'h13,
      IEX_SIGNED_LONG_MAC_OP         = 6'h14,
      IEX_SIGNED_LONG_MUL_OP         = 6'h15,
      IEX_BYTE_REVERSE_WORD_OP       = 6'h16,
      IEX_BYTE_REVERSE_HALVES_OP     = 6'h17,
      IEX_BYTE_REVERSE_LOW_SIGNED_OP = 6'h18,
      IEX_BRANCH_IF_ZERO_OP          = 6'h19,
      IEX_BRANCH_IF_NONZERO_OP       = 6'h1a,
      IEX_IRQ_DISABLE_OP             = 6'h1b,
      IEX_IRQ_ENABLE_OP              = 6'h1c,
      IEX_LOAD_MULTI_DEC_BEFORE      = 6'h1d,
      IEX_LOAD_MULTI_INC_AFTER       = 6'h1e,
      IEX_LOAD_SIGNED_BYTE_OP        = 6'h1f,
      IEX_LOAD_SIGNED_HALF_OP        = 6'h20,
      IEX_WRITE_SPECIAL_REG_OP       = 6'h21,
      IEX_READ_SPECIAL_REG_OP        = 6'h22,
      IEX_SIGNED_SATURATE_OP         = 6'h23,
      IEX_UNSIGNED_SATURATE_OP       = 6'h24
   } iex_op_t;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
      logic q;
   } iex_flags_t;

   // adder answer: carry out, overflow, sum
   typedef struct packed {
      logic        c;
      logic        v;
      logic [31:0] sum;
   } iex_alu_t;

   // multiplier request
   typedef struct packed {
      iex_op_t     op;
      logic [31:0] a;
      logic [31:0] b;
      logic [63:0] acc;
   } iex_mul_req_t;

endpackage

//--- iex_mul.sv
// Purpose: multiply unit of the execution block
// Assumes: purely combinational, result registered by the caller
// Notes:   32-bit forms use the low product word only
`timescale 1ns/10ps
module iex_mul (
   input  iex_pkg::iex_mul_req_t req,
   output logic [63:0]           res
);
   import iex_pkg::*;

   logic signed [63:0] sprod;
   logic        [63:0] uprod;

   // one signed and one plain product, shared by all forms
   always_comb begin
      sprod = $signed(req.a) * $signed(req.b);
      uprod = {32'h0000_0000, req.a} * {32'h0000_0000, req.b};
      case (req.op)
         IEX_MUL_ACCUMULATE_OP: begin
            res = {32'h0000_0000, uprod[31:0] + req.acc[31:0]};
         end
         IEX_MUL_SUBTRACT_OP: begin
            res = {32'h0000_0000, req.acc[31:0] - uprod[31:0]};
         end
         IEX_SIGNED_LONG_MAC_OP: begin
            res = sprod + req.acc;
         end
         IEX_SIGNED_LONG_MUL_OP: begin
            res = sprod;
         end
         default: begin
            res = 64'h0000_0000_0000_0000;
         end
      endcase
   end
endmodule

//--- iex_datapath.sv
// Purpose: integer execution datapath reached over apb
// Assumes: decode writes operands, then the command word to execute
// Notes:   zero wait states; results valid from the edge after the write
// What this block does
// - The second operand is either the register operand or the constant.
// - An operation runs only when its condition field passes on the flags.
// - Branch-if-nonzero takes the target only when the register is not 0.
// - Branch-if-zero takes the target only when the register is 0.
// - Interrupt disable and enable ops change the mask, never the flags.
// - Load multiple: decrement-before or increment-after, opt writeback.
// - Signed byte and halfword loads sign-extend to 32 bits.
// - Multiply-accumulate and multiply-subtract give 32 bits, no flags.
// - Signed long mac adds a 64-bit two-register accumulator in place.
// - Signed long multiply gives the 64-bit product split low and high.
// - Word byte reverse reverses all four bytes.
// - Halfword byte reverse swaps the bytes of each halfword.
// - Low signed byte reverse swaps the low half bytes and sign-extends.
// - Write special register copies a register, may set N, Z, C, V and Q.
// - Read special register copies a special register, flags untouched.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "iex_defines.svh"
module iex_datapath (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic                       irq_disabled
);
   import iex_pkg::*;

   logic [31:0]  opa_q, opa_d;
   logic [31:0]  opb_q, opb_d;
   logic [31:0]  imm_q, imm_d;
   logic [31:0]  acc_lo_q, acc_lo_d;
   logic [31:0]  acc_hi_q, acc_hi_d;
   logic [31:0]  cmd_q, cmd_d;
   logic [31:0]  res_lo_q, res_lo_d;
   logic [31:0]  res_hi_q, res_hi_d;
   logic [31:0]  target_q, target_d;
   logic [31:0]  rdata_q, rdata_d;
   iex_flags_t   flags_q, flags_d;
   logic         done_q, done_d;
   logic         taken_q, taken_d;
   logic         skipped_q, skipped_d;
   logic         irq_off_q, irq_off_d;

   logic [7:0]   addr;
   logic         addr_ok;
   logic         wr_en;
   logic         exec;
   iex_op_t      op;
   logic [3:0]   cond;
   logic [31:0]  op2;
   logic [4:0]   cnt;
   iex_mul_req_t mreq;
   logic [63:0]  mres;

   // condition check on the flag state before the operation
   function automatic logic cond_pass(input logic [3:0] cc,
                                      input iex_flags_t f);
      logic r;
      case (cc[3:1])
         3'h0: r = f.z;
         3'h1: r = f.c;
         3'h2: r = f.n;
         3'h3: r = f.v;
         3'h4: r = f.c & ~f.z;
         3'h5: r = (f.n == f.v);
         3'h6: r = ~f.z & (f.n == f.v);
         default: r = 1'b1;
      endcase
      if (cc[3:1] != 3'h7) begin
         r = r ^ cc[0];
      end
      return r;
   endfunction

   // one adder serves every add, subtract and compare form
   function automatic iex_alu_t add_c(input logic [31:0] a,
                                      input logic [31:0] b,
                                      input logic        ci);
      iex_alu_t    r;
      logic [32:0] s;
      s     = {1'b0, a} + {1'b0, b} + {32'h0000_0000, ci};
      r.sum = s[31:0];
      r.c   = s[32];
      r.v   = (a[31] == b[31]) && (s[31] != a[31]);
      return r;
   endfunction

   // shifter: {carry, result}; amount 0 keeps the old carry
   function automatic logic [32:0] shift_c(input iex_op_t     k,
                                           input logic [31:0] a,
                                           input logic [7:0]  amt,
                                           input logic        ci);
      logic [63:0] w;
      logic [32:0] r;
      w = 64'h0000_0000_0000_0000;
      r = {ci, a};
      if (amt != 8'h00) begin
         case (k)
            IEX_LSL: begin
               w = {32'h0000_0000, a} << amt;
               r = (amt > 8'd32) ? 33'h0_0000_0000 : {w[32], w[31:0]};
            end
            IEX_LSR: begin
               w = {a, 32'h0000_0000} >> amt;
               r = (amt > 8'd32) ? 33'h0_0000_0000 : {w[31], w[63:32]};
            end
            IEX_ASR: begin
               w = $signed({a, 32'h0000_0000}) >>> amt;
               r = (amt > 8'd31) ? {33{a[31]}} : {w[31], w[63:32]};
            end
            default: begin
               w = {a, a} >> amt[4:0];
               r = {w[31], w[31:0]};
            end
         endcase
      end
      return r;
   endfunction

   // saturate to n bits; bit 32 reports a clamp
   function automatic logic [32:0] sat(input logic        sgn,
                                       input logic [31:0] v,
                                       input logic [5:0]  n);
      logic signed [63:0] x;
      logic signed [63:0] hi;
      logic signed [63:0] lo;
      logic [32:0]        r;
      x  = {{32{v[31]}}, v};
      if (sgn) begin
         hi = (64'sd1 <<< (n - 6'd1)) - 64'sd1;
         lo = -(64'sd1 <<< (n - 6'd1));
      end else begin
         hi = (64'sd1 <<< n) - 64'sd1;
         lo = 64'sd0;
      end
      if (x > hi) begin
         r = {1'b1, hi[31:0]};
      end else if (x < lo) begin
         r = {1'b1, lo[31:0]};
      end else begin
         r = {1'b0, v};
      end
      return r;
   endfunction

   // apb decode; the slave never stretches a transfer
   assign addr    = paddr[7:0];
   assign wr_en   = psel & penable & pwrite;
   assign exec    = wr_en & (addr == `IEX_OFS_CMD);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign prdata  = rdata_q;
   assign irq_disabled = irq_off_q;

   always_comb begin
      case (addr)
         `IEX_OFS_OPA, `IEX_OFS_OPB, `IEX_OFS_IMM, `IEX_OFS_ACC_LO,
         `IEX_OFS_ACC_HI, `IEX_OFS_CMD, `IEX_OFS_RES_LO,
         `IEX_OFS_RES_HI, `IEX_OFS_FLAGS, `IEX_OFS_STATUS,
         `IEX_OFS_TARGET: addr_ok = 1'b1;
         default:         addr_ok = 1'b0;
      endcase
   end

   // fields of the command being written
   assign op   = iex_op_t'(pwdata[`IEX_CMD_OP_MSB:`IEX_CMD_OP_LSB]);
   assign cond = pwdata[`IEX_CMD_COND_MSB:`IEX_CMD_COND_LSB];
   assign cnt  = pwdata[`IEX_CMD_CNT_MSB:`IEX_CMD_CNT_LSB];
   assign op2  = pwdata[`IEX_CMD_USE_IMM] ? imm_q : opb_q;

   assign mreq.op  = op;
   assign mreq.a   = opa_q;
   assign mreq.b   = opb_q;
   assign mreq.acc = {acc_hi_q, acc_lo_q};

   iex_mul u_mul (
      .req (mreq),
      .res (mres)
   );

   // next state: register writes and one execution per command write
   always_comb begin
      iex_alu_t    a;
      logic [32:0] sh;
      logic [31:0] r;
      logic        setf;
      logic        arith;
      logic        logic_f;
      logic        wres;
      a       = '0;
      sh      = '0;
      r       = 32'h0000_0000;
      setf    = pwdata[`IEX_CMD_SETF];
      arith   = 1'b0;
      logic_f = 1'b0;
      wres    = 1'b1;
      opa_d     = opa_q;
      opb_d     = opb_q;
      imm_d     = imm_q;
      acc_lo_d  = acc_lo_q;
      acc_hi_d  = acc_hi_q;
      cmd_d     = cmd_q;
      res_lo_d  = res_lo_q;
      res_hi_d  = res_hi_q;
      target_d  = target_q;
      flags_d   = flags_q;
      done_d    = done_q;
      taken_d   = taken_q;
      skipped_d = skipped_q;
      irq_off_d = irq_off_q;
      // setup cycle latches read data so prdata comes from a flop
      rdata_d   = rdata_q;
      if (psel & ~penable & ~pwrite) begin
         case (addr)
            `IEX_OFS_OPA:    rdata_d = opa_q;
            `IEX_OFS_OPB:    rdata_d = opb_q;
            `IEX_OFS_IMM:    rdata_d = imm_q;
            `IEX_OFS_ACC_LO: rdata_d = acc_lo_q;
            `IEX_OFS_ACC_HI: rdata_d = acc_hi_q;
            `IEX_OFS_CMD:    rdata_d = cmd_q;
            `IEX_OFS_RES_LO: rdata_d = res_lo_q;
            `IEX_OFS_RES_HI: rdata_d = res_hi_q;
            `IEX_OFS_FLAGS:  rdata_d = {flags_q, 27'h000_0000};
            `IEX_OFS_STATUS: rdata_d = {28'h000_0000, skipped_q,
                                        irq_off_q, taken_q, done_q};
            `IEX_OFS_TARGET: rdata_d = target_q;
            default:         rdata_d = `IEX_RST_WORD;
         endcase
      end
      if (wr_en) begin
         case (addr)
            `IEX_OFS_OPA:    opa_d    = pwdata;
            `IEX_OFS_OPB:    opb_d    = pwdata;
            `IEX_OFS_IMM:    imm_d    = pwdata;
            `IEX_OFS_ACC_LO: acc_lo_d = pwdata;
            `IEX_OFS_ACC_HI: acc_hi_d = pwdata;
            `IEX_OFS_TARGET: target_d = pwdata;
            `IEX_OFS_FLAGS:  flags_d  = iex_flags_t'(pwdata[31:27]);
            default: begin
            end
         endcase
      end
      // a command that fails its condition leaves results and flags alone
      if (exec) begin
         cmd_d     = pwdata;
         done_d    = 1'b1;
         taken_d   = 1'b0;
         skipped_d = ~cond_pass(cond, flags_q);
      end
      if (exec && cond_pass(cond, flags_q)) begin
         case (op)
            IEX_ADD: begin
               a = add_c(opa_q, op2, 1'b0);
               arith = 1'b1;
            end
            IEX_ADC: begin
               a = add_c(opa_q, op2, flags_q.c);
               arith = 1'b1;
            end
            IEX_SUB, IEX_CMP: begin
               a = add_c(opa_q, ~op2, 1'b1);
               arith = 1'b1;
            end
            IEX_SBC: begin
               a = add_c(opa_q, ~op2, flags_q.c);
               arith = 1'b1;
            end
            IEX_RSB: begin
               a = add_c(op2, ~opa_q, 1'b1);
               arith = 1'b1;
            end
            IEX_CMN: begin
               a = add_c(opa_q, op2, 1'b0);
               arith = 1'b1;
            end
            IEX_AND: begin
               r = opa_q & op2;
               logic_f = 1'b1;
            end
            IEX_ORR: begin
               r = opa_q | op2;
               logic_f = 1'b1;
            end
            IEX_EOR: begin
               r = opa_q ^ op2;
               logic_f = 1'b1;
            end
            IEX_BIC: begin
               r = opa_q & ~op2;
               logic_f = 1'b1;
            end
            IEX_MOV: begin
               r = op2;
               logic_f = 1'b1;
            end
            IEX_MVN: begin
               r = ~op2;
               logic_f = 1'b1;
            end
            IEX_LSL, IEX_LSR, IEX_ASR, IEX_ROR: begin
               sh = shift_c(op, opa_q, op2[7:0], flags_q.c);
               r  = sh[31:0];
               logic_f = 1'b1;
            end
            IEX_MUL_ACCUMULATE_OP, IEX_MUL_SUBTRACT_OP: begin
               r = mres[31:0];
            end
            IEX_SIGNED_LONG_MAC_OP, IEX_SIGNED_LONG_MUL_OP: begin
               r        = mres[31:0];
               res_hi_d = mres[63:32];
               acc_hi_d = (op == IEX_SIGNED_LONG_MAC_OP) ?
                          mres[63:32] : acc_hi_q;
               acc_lo_d = (op == IEX_SIGNED_LONG_MAC_OP) ?
                          mres[31:0] : acc_lo_q;
            end
            IEX_BYTE_REVERSE_WORD_OP: begin
               r = {opb_q[7:0], opb_q[15:8], opb_q[23:16],
                    opb_q[31:24]};
            end
            IEX_BYTE_REVERSE_HALVES_OP: begin
               r = {opb_q[23:16], opb_q[31:24], opb_q[7:0],
                    opb_q[15:8]};
            end
            IEX_BYTE_REVERSE_LOW_SIGNED_OP: begin
               r = {{16{opb_q[7]}}, opb_q[7:0], opb_q[15:8]};
            end
            IEX_BRANCH_IF_ZERO_OP: begin
               taken_d = (opa_q == 32'h0000_0000);
               r = taken_d ? target_q : res_lo_q;
            end
            IEX_BRANCH_IF_NONZERO_OP: begin
               taken_d = (opa_q != 32'h0000_0000);
               r = taken_d ? target_q : res_lo_q;
            end
            IEX_IRQ_DISABLE_OP: begin
               irq_off_d = 1'b1;
               wres = 1'b0;
            end
            IEX_IRQ_ENABLE_OP: begin
               irq_off_d = 1'b0;
               wres = 1'b0;
            end
            // first address low, final base high
            IEX_LOAD_MULTI_DEC_BEFORE: begin
               r = opa_q - {25'h000_0000, cnt, 2'b00};
               res_hi_d = pwdata[`IEX_CMD_WBACK] ? r : opa_q;
            end
            IEX_LOAD_MULTI_INC_AFTER: begin
               r = opa_q;
               res_hi_d = pwdata[`IEX_CMD_WBACK] ?
                  opa_q + {25'h000_0000, cnt, 2'b00} : opa_q;
            end
            IEX_LOAD_SIGNED_BYTE_OP: begin
               r = {{24{opb_q[7]}}, opb_q[7:0]};
            end
            IEX_LOAD_SIGNED_HALF_OP: begin
               r = {{16{opb_q[15]}}, opb_q[15:0]};
            end
            IEX_WRITE_SPECIAL_REG_OP: begin
               wres = 1'b0;
               if (imm_q[0]) begin
                  irq_off_d = opb_q[0];
               end else begin
                  flags_d = iex_flags_t'(opb_q[31:27]);
               end
            end
            IEX_READ_SPECIAL_REG_OP: begin
               r = imm_q[0] ? {31'h0000_0000, irq_off_q}
                            : {flags_q, 27'h000_0000};
            end
            IEX_SIGNED_SATURATE_OP, IEX_UNSIGNED_SATURATE_OP: begin
               sh = sat(op == IEX_SIGNED_SATURATE_OP, opb_q, imm_q[5:0]);
               r  = sh[31:0];
               if (sh[32]) begin
                  flags_d.q = 1'b1;
               end
            end
            default: begin
               wres = 1'b0;
            end
         endcase
         if (arith) begin
            r = a.sum;
         end
         // compares only set flags, they write no result
         if (op == IEX_CMP || op == IEX_CMN) begin
            wres = 1'b0;
            setf = 1'b1;
         end
         if (wres) begin
            res_lo_d = r;
         end
         if (arith && setf) begin
            flags_d.n = a.sum[31];
            flags_d.z = (a.sum == 32'h0000_0000);
            flags_d.c = a.c;
            flags_d.v = a.v;
         end
         if (logic_f && setf) begin
            flags_d.n = r[31];
            flags_d.z = (r == 32'h0000_0000);
            flags_d.c = (op >= IEX_LSL && op <= IEX_ROR) ?
                        sh[32] : flags_q.c;
         end
      end
   end

   // plain register stage; reset loads constants only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opa_q     <= `IEX_RST_WORD;
         opb_q     <= `IEX_RST_WORD;
         imm_q     <= `IEX_RST_WORD;
         acc_lo_q  <= `IEX_RST_WORD;
         acc_hi_q  <= `IEX_RST_WORD;
         cmd_q     <= `IEX_RST_WORD;
         res_lo_q  <= `IEX_RST_WORD;
         res_hi_q  <= `IEX_RST_WORD;
         target_q  <= `IEX_RST_WORD;
         rdata_q   <= `IEX_RST_WORD;
         flags_q   <= iex_flags_t'(`IEX_RST_FLAGS);
         done_q    <= 1'b0;
         taken_q   <= 1'b0;
         skipped_q <= 1'b0;
         irq_off_q <= 1'b0;
      end else begin
         opa_q     <= opa_d;
         opb_q     <= opb_d;
         imm_q     <= imm_d;
         acc_lo_q  <= acc_lo_d;
         acc_hi_q  <= acc_hi_d;
         cmd_q     <= cmd_d;
         res_lo_q  <= res_lo_d;
         res_hi_q  <= res_hi_d;
         target_q  <= target_d;
         rdata_q   <= rdata_d;
         flags_q   <= flags_d;
         done_q    <= done_d;
         taken_q   <= taken_d;
         skipped_q <= skipped_d;
         irq_off_q <= irq_off_d;
      end
   end
endmodule

//--- iex_apb_host.sv
// Purpose: apb master in place of decode and register file
// Assumes: bench calls xfer, one transfer at a time
// Notes:   idle cycle between transfers, so no double drive
`timescale 1ns/10ps
module iex_apb_host (
   input  wire logic        pclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [31:0] paddr,
   output logic      [31:0] pwdata
);
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // setup, then access held until pready; answer taken at that edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [32:0] r);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, 24'h0, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (!pready);
      r = {pslverr, prdata};
      {psel, penable} <= 2'b00;
   endtask
endmodule

//--- iex_datapath_chk.sv
// Purpose: port checks of the execution datapath
// Assumes: results latch at the command edge
// Notes:   only always-run commands are shadowed
`timescale 1ns/10ps
module iex_datapath_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq_disabled
);
   logic [31:0] opb_q, shb_q;
   logic [5:0]  sop_q;
   logic [7:0]  b3, b2, b1, b0;
   logic        w, cw, rs;
   // write, command write, result read setup
   assign w = psel && penable && pwrite;
   assign cw = w && paddr[7:0] == 8'h14;
   assign rs = psel && !penable && !pwrite && paddr[7:0] == 8'h18;
   assign {b3, b2, b1, b0} = shb_q;
   // skipped commands would make the shadow lie, so only code e
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {opb_q, shb_q, sop_q} <= '0;
      end else begin
         if (w && paddr[7:0] == 8'h04) opb_q <= pwdata;
         if (cw) shb_q <= opb_q;
         if (cw) sop_q <= pwdata[11:8] == 4'he ? pwdata[5:0] : 6'h0;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_rev_word: assert property (rs && sop_q == 6'h16 |=>
      prdata == {b0, b1, b2, b3}) else $error("word reverse");
   a_rev_halves: assert property (rs && sop_q == 6'h17 |=>
      prdata == {b2, b3, b0, b1}) else $error("half reverse");
   a_rev_low: assert property (rs && sop_q == 6'h18 |=>
      prdata == {{16{b0[7]}}, b0, b1}) else $error("low reverse");
   a_sload_byte: assert property (rs && sop_q == 6'h1f |=>
      prdata == {{24{b0[7]}}, b0}) else $error("byte load");
   a_sload_half: assert property (rs && sop_q == 6'h20 |=>
      prdata == {{16{b1[7]}}, b1, b0}) else $error("half load");
   a_irq_off_cause: assert property ($rose(irq_disabled) |->
      $past(cw && pwdata[5:0] inside {6'h1b, 6'h21})) else $error("mask on");
   a_irq_on_cause: assert property ($fell(irq_disabled) |->
      $past(cw && pwdata[5:0] inside {6'h1c, 6'h21})) else $error("mask off");
   a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=>
      $stable(prdata)) else $error("read data moved");
   c_irq_off: cover property (cw && pwdata[5:0] == 6'h1b);
   c_rev: cover property (rs && sop_q == 6'h16);
   c_err: cover property (pslverr);
endmodule
bind iex_datapath iex_datapath_chk u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq_disabled(irq_disabled));

//--- iex_datapath_bench.sv
// Purpose: self-checking bench of the execution datapath
// Assumes: results readable on the transfer after the command
// Notes:   about 260 cycles; guard far above that
`timescale 1ns/10ps
module iex_datapath_bench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, irq_disabled;
   logic [31:0] paddr, pwdata, prdata;
   logic [32:0] r;
   int          mismatches = 0, samples_checked = 0, cycles = 0;
   always #25 pclk = ~pclk;
   iex_datapath u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_disabled(irq_disabled));
   iex_apb_host u_host (.pclk(pclk), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));
   task automatic test_done();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // hang guard
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) mismatches++;
      if (seen !== exp) $display("ERROR %0t seen=%h exp=%h", $time, seen, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      u_host.xfer(1'b0, a, 32'h0, r);
      chk(r[31:0], e);
   endtask
   // run one command word, then read back one register
   task automatic x(input logic [31:0] c, input logic [7:0] a,
                    input logic [31:0] e);
      wr(8'h14, c);
      rd(a, e);
   endtask
   task automatic t_alu();
      wr(8'h00, 32'h5);
      wr(8'h04, 32'h3);
      wr(8'h08, 32'ha);
      x(32'h0e01, 8'h18, 32'h8);
      x(32'h1e01, 8'h18, 32'hf);
      x(32'h0e06, 8'h20, 32'h2000_0000);
      x(32'h0001, 8'h18, 32'hf);
      x(32'h0101, 8'h18, 32'h8);
      x(32'h2e0d, 8'h20, 32'ha000_0000);
      x(32'h2e0e, 8'h20, 32'h0);
      rd(8'h18, 32'h28);
      x(32'h2e10, 8'h20, 32'h6000_0000);
      wr(8'h04, 32'ha000_0000);
      x(32'h0e21, 8'h20, 32'ha000_0000);
      x(32'h0e22, 8'h18, 32'ha000_0000);
      wr(8'h04, 32'h1000);
      wr(8'h08, 32'h8);
      x(32'h0e23, 8'h20, 32'ha800_0000);
      rd(8'h18, 32'h7f);
      rd(8'h3c, 32'h0);
      chk({31'h0, r[32]}, 32'h1);
      $display("alu test end");
   endtask
   task automatic t_flow();
      wr(8'h28, 32'h100);
      wr(8'h00, 32'h0);
      x(32'h0e19, 8'h18, 32'h100);
      wr(8'h28, 32'h200);
      x(32'h0e1a, 8'h18, 32'h100);
      wr(8'h00, 32'h1000);
      x(32'h0e19, 8'h18, 32'h100);
      x(32'h0e1a, 8'h18, 32'h200);
      x(32'h4_4e1d, 8'h1c, 32'hff0);
      x(32'h4_4e1e, 8'h1c, 32'h1010);
      x(32'h4_0e1e, 8'h1c, 32'h1000);
      wr(8'h20, 32'hf000_0000);
      x(32'h0e1b, 8'h20, 32'hf000_0000);
      chk({31'h0, irq_disabled}, 32'h1);
      x(32'h0e1c, 8'h20, 32'hf000_0000);
      chk({31'h0, irq_disabled}, 32'h0);
      $display("flow test end");
   endtask
   task automatic t_data();
      wr(8'h04, 32'h1234_5680);
      x(32'h0e16, 8'h18, 32'h8056_3412);
      x(32'h0e17, 8'h18, 32'h3412_8056);
      x(32'h0e18, 8'h18, 32'hffff_8056);
      x(32'h0e1f, 8'h18, 32'hffff_ff80);
      x(32'h0e20, 8'h18, 32'h5680);
      wr(8'h00, 32'hffff_fffe);
      wr(8'h04, 32'h3);
      wr(8'h0c, 32'ha);
      wr(8'h10, 32'h0);
      wr(8'h20, 32'h0);
      x(32'h2e12, 8'h18, 32'h4);
      x(32'h2e13, 8'h20, 32'h0);
      rd(8'h18, 32'h10);
      x(32'h0e15, 8'h1c, 32'hffff_ffff);
      rd(8'h18, 32'hffff_fffa);
      x(32'h0e14, 8'h18, 32'h4);
      rd(8'h1c, 32'h0);
      $display("data test end");
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_alu();
      t_flow();
      t_data();
      test_done();
   end
endmodule
